// ---- design/sbs_map.svh ----
// constants for the split bulk/control start-split buffer logic
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_CLK_MHZ 100
`define SBS_NUM_BUFS 2
`define SBS_DATA_W 8
`define SBS_ADDR_W 7
`define SBS_EP_W 4
`define SBS_NO_ROOM_IDX 0
`define SBS_ERR_LIMIT 3
`define SBS_CNT_W 16
// device gives up on a missing token or data packet after this
`define SBS_PKT_TIMEOUT_NS 400
`define SBS_PKT_TIMEOUT_CYC \
   ((`SBS_PKT_TIMEOUT_NS * `SBS_CLK_MHZ + 999) / 1000)
// host gives up waiting for a handshake after this
`define SBS_RSP_TIMEOUT_NS 800
`define SBS_RSP_TIMEOUT_CYC \
   ((`SBS_RSP_TIMEOUT_NS * `SBS_CLK_MHZ + 999) / 1000)

`endif

// ---- design/sbs_pkg.sv ----
// types shared by both ends of the split start-split link
package sbs_pkg;

   typedef enum logic [1:0] {PID_OUT, PID_IN, PID_SETUP} sbs_pid_t;

   typedef enum logic [2:0] {
      HSK_ACK, HSK_NAK, HSK_NYET, HSK_STALL, HSK_DATA
   } sbs_hsk_t;

   typedef enum logic [1:0] {BUF_OLD, BUF_PENDING, BUF_READY} sbs_buf_state_t;

   typedef enum logic [2:0] {
      RES_ACK, RES_NAK, RES_NYET, RES_STALL, RES_DATA, RES_HALT, RES_REFUSED
   } sbs_res_t;

endpackage : sbs_pkg

// ---- design/sbs_link_if.sv ----
// high-speed split link between host controller end and translator end
`timescale 1ns/1ps
`include "sbs_map.svh"

interface sbs_link_if #(parameter int DATA_W = `SBS_DATA_W);
   // host to translator
   logic ss_valid;
   logic cs_valid;
   logic ss_ctrl;
   logic tok_valid;
   sbs_pkg::sbs_pid_t tok_pid;
   logic [`SBS_ADDR_W-1:0] tok_addr;
   logic [`SBS_EP_W-1:0] tok_endp;
   logic data_valid;
   logic [DATA_W-1:0] data_word;
   logic data_crc_ok;
   // translator to host
   logic hsk_valid;
   sbs_pkg::sbs_hsk_t hsk_code;
   logic [DATA_W-1:0] hsk_data;

   modport hc (
      output ss_valid, cs_valid, ss_ctrl, tok_valid, tok_pid, tok_addr,
      output tok_endp, data_valid, data_word, data_crc_ok,
      input hsk_valid, hsk_code, hsk_data
   );

   modport tt (
      input ss_valid, cs_valid, ss_ctrl, tok_valid, tok_pid, tok_addr,
      input tok_endp, data_valid, data_word, data_crc_ok,
      output hsk_valid, hsk_code, hsk_data
   );
endinterface : sbs_link_if

// ---- design/sbs_tt_end.sv ----
// translator end: bulk/control start-split buffers and handshakes
// How it works
// [RQ1] at least two bulk/control transaction buffers
// [RQ2] buffer keeps request, payload, then result
// [RQ3] accept start-split whenever a buffer fits
// [RQ4] answered buffer is free for next start-split
// [RQ5] order follows free space and host order
// [RQ6] host tracks split versus plain transactions
// [RQ7] match address, endpoint; direction only for bulk
// [RQ8] at most one buffered transaction per endpoint
// [RQ9] match pending or ready means retry
// [RQ10] no match: take an old buffer
// [RQ11] nothing fits: no room, index zero
// [RQ12] missing token or data: stay silent
// [RQ13] bad data crc: stay silent
// [RQ14] host sends setup token for setup stage
// [RQ15] host retries until error count three
// [RQ16] no buffer space: answer nak
// [RQ17] nak leaves host error count alone
// [RQ18] space available: store and answer ack
// [RQ19] after ack host does complete-split next; host refuses a start-split only to the last acked endpoint
// [RQ20] duplicate start-split: ack, drop payload
// [RQ21] buffers come out of reset old
// [RQ22] downstream finish: pending to ready, keep result
// [RQ23] answered complete-split: ready to old
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_tt_end #(
   parameter int NUM_BUFS = `SBS_NUM_BUFS,
   parameter int DATA_W = `SBS_DATA_W,
   parameter int TO_CYC = `SBS_PKT_TIMEOUT_CYC,
   parameter int IDX_W = (NUM_BUFS > 1) ? $clog2(NUM_BUFS) : 1
) (
   input wire logic clock,
   input wire logic rst,
   sbs_link_if.tt lnk,
   output logic dn_req_valid,
   output logic [IDX_W-1:0] dn_req_idx,
   output logic [`SBS_ADDR_W-1:0] dn_req_addr,
   output logic [`SBS_EP_W-1:0] dn_req_endp,
   output sbs_pkg::sbs_pid_t dn_req_pid,
   output logic [DATA_W-1:0] dn_req_data,
   input wire logic dn_done,
   input wire logic [IDX_W-1:0] dn_done_idx,
   input wire sbs_pkg::sbs_hsk_t dn_done_result,
   input wire logic [DATA_W-1:0] dn_done_data
);

   typedef enum {S_IDLE, S_TOK, S_DATA, S_SS_ANS, S_CS_ANS} sbs_tt_state_t;

   sbs_tt_state_t st_q;
   logic [`SBS_CNT_W-1:0] cnt_q;
   logic is_cs_q;
   logic ctrl_q;
   sbs_pkg::sbs_pid_t pid_q;
   logic [`SBS_ADDR_W-1:0] addr_q;
   logic [`SBS_EP_W-1:0] endp_q;
   logic [DATA_W-1:0] payload_q;
   logic tok_dir;
   logic timed_out;

   // per-buffer storage, flip-flops addressed by index
   logic [`SBS_ADDR_W-1:0] b_addr_q [NUM_BUFS];
   logic [`SBS_EP_W-1:0] b_endp_q [NUM_BUFS];
   sbs_pkg::sbs_pid_t b_pid_q [NUM_BUFS];
   logic [DATA_W-1:0] b_data_q [NUM_BUFS];
   sbs_pkg::sbs_hsk_t b_res_q [NUM_BUFS];
   sbs_pkg::sbs_buf_state_t b_state_q [NUM_BUFS]; // RQ1
   logic [NUM_BUFS-1:0] b_issued_q;
   logic [NUM_BUFS-1:0] ep_hit;
   logic [NUM_BUFS-1:0] is_old;
   logic [NUM_BUFS-1:0] is_live;

   logic start_split_is_new;
   logic start_split_is_retry;
   logic start_split_no_room;
   logic [IDX_W-1:0] bulk_ctrl_buffer_select;
   logic cs_hit;
   logic [IDX_W-1:0] cs_idx;
   logic iss_hit;
   logic [IDX_W-1:0] iss_idx;
   logic accept_ack_path;
   logic duplicate_ack_path;
   logic full_nak_path;
   logic cs_take;
   logic dn_busy_q;

   assign tok_dir = (pid_q == sbs_pkg::PID_IN);
   assign timed_out = (cnt_q == TO_CYC[`SBS_CNT_W-1:0] - 1'b1);

   // classification of the captured start-split
   assign accept_ack_path = (st_q == S_SS_ANS) && start_split_is_new; // RQ18
   assign duplicate_ack_path = (st_q == S_SS_ANS) && start_split_is_retry;
   assign full_nak_path = (st_q == S_SS_ANS) && start_split_no_room; // RQ16
   assign cs_take = (st_q == S_CS_ANS) && cs_hit &&
      (b_state_q[cs_idx] == sbs_pkg::BUF_READY);

   // per-buffer compare terms and storage
   for (genvar i = 0; i < NUM_BUFS; i++) begin : g_buf
      // control endpoints are bidirectional, so direction is not compared
      assign ep_hit[i] = (addr_q == b_addr_q[i]) && (endp_q == b_endp_q[i]) &&
         (ctrl_q || (tok_dir == (b_pid_q[i] == sbs_pkg::PID_IN))); // RQ7
      assign is_old[i] = (b_state_q[i] == sbs_pkg::BUF_OLD);
      assign is_live[i] = !is_old[i];

      // one buffer holds one downstream transaction at a time
      always_ff @(posedge clock)
      begin
         if (rst)
         begin
            b_state_q[i] <= sbs_pkg::BUF_OLD; // RQ21
            b_addr_q[i] <= '0;
            b_endp_q[i] <= '0;
            b_pid_q[i] <= sbs_pkg::PID_OUT;
            b_data_q[i] <= '0;
            b_res_q[i] <= sbs_pkg::HSK_NAK;
            b_issued_q[i] <= 1'b0;
         end
         else if (accept_ack_path && bulk_ctrl_buffer_select == IDX_W'(i))
         begin
            // store request and payload, wait for downstream
            b_state_q[i] <= sbs_pkg::BUF_PENDING; // RQ2
            b_addr_q[i] <= addr_q;
            b_endp_q[i] <= endp_q;
            b_pid_q[i] <= pid_q;
            b_data_q[i] <= payload_q;
            b_issued_q[i] <= 1'b0;
         end
         else if (dn_done && dn_done_idx == IDX_W'(i) &&
            b_state_q[i] == sbs_pkg::BUF_PENDING)
         begin
            b_state_q[i] <= sbs_pkg::BUF_READY; // RQ22
            b_res_q[i] <= dn_done_result;
            if (b_pid_q[i] == sbs_pkg::PID_IN)
               b_data_q[i] <= dn_done_data;
         end
         else if (cs_take && cs_idx == IDX_W'(i))
         begin
            // result kept, buffer reusable by any endpoint
            b_state_q[i] <= sbs_pkg::BUF_OLD; // RQ23 RQ4
         end
         else if (dn_req_valid == 1'b0 && !dn_busy_q && iss_hit &&
            iss_idx == IDX_W'(i))
         begin
            b_issued_q[i] <= 1'b1;
         end
      end
   end

   // buffer search: first endpoint match wins, else an old buffer
   always_comb
   begin
      logic hit;
      hit = 1'b0;
      start_split_is_new = 1'b0;
      start_split_is_retry = 1'b0;
      start_split_no_room = 1'b1; // RQ11
      bulk_ctrl_buffer_select = IDX_W'(`SBS_NO_ROOM_IDX); // RQ11
      cs_hit = 1'b0;
      cs_idx = '0;
      for (int i = 0; i < NUM_BUFS; i++)
      begin
         if (!hit)
         begin
            if (ep_hit[i])
            begin
               hit = 1'b1; // RQ9
               start_split_no_room = 1'b0;
               start_split_is_retry = is_live[i]; // RQ9 RQ8
               start_split_is_new = is_old[i];
               bulk_ctrl_buffer_select = i[IDX_W-1:0];
            end
            else if (is_old[i])
            begin
               start_split_no_room = 1'b0; // RQ10
               start_split_is_new = 1'b1;
               bulk_ctrl_buffer_select = i[IDX_W-1:0];
            end
         end
         if (!cs_hit && ep_hit[i] && is_live[i])
         begin
            cs_hit = 1'b1;
            cs_idx = i[IDX_W-1:0];
         end
      end
   end

   // packet sequencing; order of acceptance is simply arrival order
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q <= S_IDLE;
         cnt_q <= '0;
         is_cs_q <= 1'b0;
         ctrl_q <= 1'b0;
         pid_q <= sbs_pkg::PID_OUT;
         addr_q <= '0;
         endp_q <= '0;
         payload_q <= '0;
      end
      else
      begin
         case (st_q)
            S_IDLE:
            begin
               cnt_q <= '0;
               if (lnk.ss_valid || lnk.cs_valid)
               begin
                  is_cs_q <= lnk.cs_valid && !lnk.ss_valid;
                  ctrl_q <= lnk.ss_ctrl;
                  st_q <= S_TOK; // RQ5 RQ3
               end
            end
            S_TOK:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (lnk.tok_valid)
               begin
                  cnt_q <= '0;
                  pid_q <= lnk.tok_pid;
                  addr_q <= lnk.tok_addr;
                  endp_q <= lnk.tok_endp;
                  if (is_cs_q)
                     st_q <= S_CS_ANS;
                  else if (lnk.tok_pid == sbs_pkg::PID_IN)
                     st_q <= S_SS_ANS;
                  else
                     st_q <= S_DATA;
               end
               else if (timed_out)
                  st_q <= S_IDLE; // RQ12
            end
            S_DATA:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (lnk.data_valid)
               begin
                  payload_q <= lnk.data_word;
                  // a corrupt packet leaves the buffers untouched
                  st_q <= lnk.data_crc_ok ? S_SS_ANS : S_IDLE; // RQ13
               end
               else if (timed_out)
                  st_q <= S_IDLE; // RQ12
            end
            S_SS_ANS:
               st_q <= S_IDLE;
            S_CS_ANS:
               st_q <= S_IDLE;
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   // handshake back to the host; silence on every error path
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         lnk.hsk_valid <= 1'b0;
         lnk.hsk_code <= sbs_pkg::HSK_ACK;
         lnk.hsk_data <= '0;
      end
      else
      begin
         lnk.hsk_valid <= (st_q == S_SS_ANS) || (st_q == S_CS_ANS);
         if (accept_ack_path || duplicate_ack_path)
            lnk.hsk_code <= sbs_pkg::HSK_ACK; // RQ18 RQ20
         else if (full_nak_path)
            lnk.hsk_code <= sbs_pkg::HSK_NAK; // RQ16
         else if (st_q == S_CS_ANS)
         begin
            if (!cs_hit)
               lnk.hsk_code <= sbs_pkg::HSK_STALL;
            else if (b_state_q[cs_idx] == sbs_pkg::BUF_PENDING)
               lnk.hsk_code <= sbs_pkg::HSK_NYET;
            else
               lnk.hsk_code <= b_res_q[cs_idx]; // RQ4
            lnk.hsk_data <= b_data_q[cs_idx];
         end
      end
   end

   // hand pending buffers one at a time to the downstream handler
   always_comb
   begin
      iss_hit = 1'b0;
      iss_idx = '0;
      for (int i = NUM_BUFS - 1; i >= 0; i--)
      begin
         if (b_state_q[i] == sbs_pkg::BUF_PENDING && !b_issued_q[i])
         begin
            iss_hit = 1'b1;
            iss_idx = i[IDX_W-1:0];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dn_req_valid <= 1'b0;
         dn_busy_q <= 1'b0;
         dn_req_idx <= '0;
         dn_req_addr <= '0;
         dn_req_endp <= '0;
         dn_req_pid <= sbs_pkg::PID_OUT;
         dn_req_data <= '0;
      end
      else
      begin
         dn_req_valid <= 1'b0;
         if (dn_done)
            dn_busy_q <= 1'b0;
         if (!dn_req_valid && !dn_busy_q && iss_hit)
         begin
            dn_req_valid <= 1'b1;
            dn_busy_q <= 1'b1;
            dn_req_idx <= iss_idx;
            dn_req_addr <= b_addr_q[iss_idx];
            dn_req_endp <= b_endp_q[iss_idx];
            dn_req_pid <= b_pid_q[iss_idx];
            dn_req_data <= b_data_q[iss_idx];
         end
      end
   end

endmodule : sbs_tt_end

// ---- design/sbs_hc_end.sv ----
// host controller end: issues split transactions and counts errors
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_hc_end #(
   parameter int DATA_W = `SBS_DATA_W,
   parameter int TO_CYC = `SBS_RSP_TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   sbs_link_if.hc lnk,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_complete,
   input wire sbs_pkg::sbs_pid_t cmd_pid,
   input wire logic cmd_ctrl,
   input wire logic [`SBS_ADDR_W-1:0] cmd_addr,
   input wire logic [`SBS_EP_W-1:0] cmd_endp,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic cmd_bad_crc,
   input wire logic cmd_drop_token,
   output logic res_valid,
   output sbs_pkg::sbs_res_t res_code,
   output logic [DATA_W-1:0] res_data,
   output logic [1:0] res_err_count
);

   typedef enum {H_IDLE, H_SPLIT, H_TOK, H_DATA, H_WAIT} sbs_hc_state_t;

   sbs_hc_state_t st_q;
   logic [`SBS_CNT_W-1:0] cnt_q;
   logic cs_q;
   logic ctrl_q;
   sbs_pkg::sbs_pid_t pid_q;
   logic [`SBS_ADDR_W-1:0] addr_q;
   logic [`SBS_EP_W-1:0] endp_q;
   logic [DATA_W-1:0] data_q;
   logic bad_crc_q;
   logic drop_q;
   logic [1:0] err_q;
   logic wait_cs_q;
   logic [`SBS_ADDR_W-1:0] wait_addr_q;
   logic [`SBS_EP_W-1:0] wait_endp_q;
   logic blocked;

   // only one acked endpoint is tracked; a second one is not refused
   assign blocked = wait_cs_q && !cmd_complete &&
      (cmd_addr == wait_addr_q) && (cmd_endp == wait_endp_q); // RQ19

   // every command here is a split transaction, so nothing else tracks it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_q <= H_IDLE;
         cnt_q <= '0;
         cmd_ready <= 1'b0;
         cs_q <= 1'b0;
         ctrl_q <= 1'b0;
         pid_q <= sbs_pkg::PID_OUT;
         addr_q <= '0;
         endp_q <= '0;
         data_q <= '0;
         bad_crc_q <= 1'b0;
         drop_q <= 1'b0;
         err_q <= '0;
         res_valid <= 1'b0;
         res_code <= sbs_pkg::RES_ACK;
         res_data <= '0;
         res_err_count <= '0;
         wait_cs_q <= 1'b0;
         wait_addr_q <= '0;
         wait_endp_q <= '0;
         lnk.ss_valid <= 1'b0;
         lnk.cs_valid <= 1'b0;
         lnk.ss_ctrl <= 1'b0;
         lnk.tok_valid <= 1'b0;
         lnk.tok_pid <= sbs_pkg::PID_OUT;
         lnk.tok_addr <= '0;
         lnk.tok_endp <= '0;
         lnk.data_valid <= 1'b0;
         lnk.data_word <= '0;
         lnk.data_crc_ok <= 1'b0;
      end
      else
      begin
         res_valid <= 1'b0;
         lnk.ss_valid <= 1'b0;
         lnk.cs_valid <= 1'b0;
         lnk.tok_valid <= 1'b0;
         lnk.data_valid <= 1'b0;
         case (st_q)
            H_IDLE:
            begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready)
               begin
                  cmd_ready <= 1'b0;
                  cs_q <= cmd_complete; // RQ6
                  ctrl_q <= cmd_ctrl;
                  pid_q <= cmd_pid;
                  addr_q <= cmd_addr;
                  endp_q <= cmd_endp;
                  data_q <= cmd_data;
                  bad_crc_q <= cmd_bad_crc;
                  drop_q <= cmd_drop_token;
                  err_q <= '0;
                  if (blocked)
                  begin
                     res_valid <= 1'b1;
                     res_code <= sbs_pkg::RES_REFUSED; // RQ19
                     res_err_count <= '0;
                     cmd_ready <= 1'b1;
                  end
                  else
                     st_q <= H_SPLIT;
               end
            end
            H_SPLIT:
            begin
               lnk.ss_valid <= !cs_q;
               lnk.cs_valid <= cs_q;
               lnk.ss_ctrl <= ctrl_q;
               st_q <= H_TOK;
            end
            H_TOK:
            begin
               lnk.tok_valid <= !drop_q;
               // setup stage is a setup token, never out
               lnk.tok_pid <= pid_q; // RQ14
               lnk.tok_addr <= addr_q;
               lnk.tok_endp <= endp_q;
               cnt_q <= '0;
               st_q <= (!cs_q && pid_q != sbs_pkg::PID_IN) ? H_DATA : H_WAIT;
            end
            H_DATA:
            begin
               lnk.data_valid <= 1'b1;
               lnk.data_word <= data_q;
               lnk.data_crc_ok <= !bad_crc_q;
               st_q <= H_WAIT;
            end
            H_WAIT:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (lnk.hsk_valid)
               begin
                  // nak costs nothing on the error count
                  res_valid <= 1'b1; // RQ17
                  res_data <= lnk.hsk_data;
                  res_err_count <= err_q;
                  cmd_ready <= 1'b1;
                  st_q <= H_IDLE;
                  case (lnk.hsk_code)
                     sbs_pkg::HSK_ACK: res_code <= sbs_pkg::RES_ACK;
                     sbs_pkg::HSK_NAK: res_code <= sbs_pkg::RES_NAK;
                     sbs_pkg::HSK_NYET: res_code <= sbs_pkg::RES_NYET;
                     sbs_pkg::HSK_STALL: res_code <= sbs_pkg::RES_STALL;
                     default: res_code <= sbs_pkg::RES_DATA;
                  endcase
                  if (!cs_q && lnk.hsk_code == sbs_pkg::HSK_ACK)
                  begin
                     wait_cs_q <= 1'b1; // RQ19
                     wait_addr_q <= addr_q;
                     wait_endp_q <= endp_q;
                  end
                  else if (cs_q && lnk.hsk_code != sbs_pkg::HSK_NYET &&
                     addr_q == wait_addr_q && endp_q == wait_endp_q)
                     wait_cs_q <= 1'b0;
               end
               else if (cnt_q == TO_CYC[`SBS_CNT_W-1:0] - 1'b1)
               begin
                  // injected faults are one-shot so the retry is clean
                  err_q <= err_q + 1'b1;
                  bad_crc_q <= 1'b0;
                  drop_q <= 1'b0;
                  if (err_q + 1'b1 >= 2'(`SBS_ERR_LIMIT))
                  begin
                     res_valid <= 1'b1; // RQ15
                     res_code <= sbs_pkg::RES_HALT;
                     res_err_count <= err_q + 1'b1;
                     cmd_ready <= 1'b1;
                     st_q <= H_IDLE;
                  end
                  else
                     st_q <= H_SPLIT; // RQ15
               end
            end
            default:
               st_q <= H_IDLE;
         endcase
      end
   end

endmodule : sbs_hc_end

// ---- sim/sbs_link_sva.sv ----
// link checker for the split start-split translator
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_link_sva (
   input wire logic clock,
   input wire logic rst,
   input wire logic ss_valid,
   input wire logic cs_valid,
   input wire logic ss_ctrl,
   input wire logic tok_valid,
   input wire sbs_pkg::sbs_pid_t tok_pid,
   input wire logic data_valid,
   input wire logic data_crc_ok,
   input wire logic hsk_valid,
   input wire sbs_pkg::sbs_hsk_t hsk_code
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic in_ss_q;

   // which kind of split the next answer belongs to
   always_ff @(posedge clock)
   begin
      if (rst)
         in_ss_q <= 1'b0;
      else if (ss_valid)
         in_ss_q <= 1'b1;
      else if (cs_valid)
         in_ss_q <= 1'b0;
   end

   AST_GOOD_DATA_ANSWERED: assert property (data_valid && data_crc_ok
      |-> ##2 hsk_valid) else $error("no answer after good data");
   AST_BAD_CRC_SILENT: assert property (data_valid && !data_crc_ok
      |-> ##1 !hsk_valid [*3]) else $error("answer after bad data");
   AST_ANSWER_NEEDS_PACKET: assert property (hsk_valid |->
      $past(tok_valid, 2) || $past(data_valid && data_crc_ok, 2))
      else $error("answer without a packet");
   AST_SS_ACK_OR_NAK: assert property (hsk_valid && in_ss_q |->
      hsk_code inside {sbs_pkg::HSK_ACK, sbs_pkg::HSK_NAK})
      else $error("bad start-split answer");
   AST_IN_SS_ANSWERED: assert property (ss_valid ##1 (tok_valid &&
      tok_pid == sbs_pkg::PID_IN) |-> ##2 hsk_valid)
      else $error("in start-split unanswered");
   AST_CS_ANSWERED: assert property (cs_valid ##1 tok_valid |->
      ##2 hsk_valid) else $error("complete-split unanswered");
   AST_SETUP_AFTER_CTRL: assert property (tok_valid && tok_pid ==
      sbs_pkg::PID_SETUP |-> $past((ss_valid || cs_valid) && ss_ctrl))
      else $error("setup token off a control split");
   AST_HSK_ONE_CYCLE: assert property (hsk_valid |=> !hsk_valid)
      else $error("answer longer than a cycle");

   cover property (hsk_valid && hsk_code == sbs_pkg::HSK_NAK);
   cover property (hsk_valid && hsk_code == sbs_pkg::HSK_NYET);
   cover property (hsk_valid && hsk_code == sbs_pkg::HSK_DATA);
   cover property (data_valid && !data_crc_ok);
endmodule : sbs_link_sva

// ---- sim/testbench.sv ----
// self-checking bench: both link ends, downstream stand-in, checker
`timescale 1ns/1ps
`include "sbs_map.svh"

module testbench;
   logic clock, rst, cmd_valid, cmd_ready, cmd_complete, cmd_ctrl;
   logic cmd_bad_crc, cmd_drop_token, res_valid, dn_req_valid, dn_done;
   logic dn_hold, pend;
   sbs_pkg::sbs_pid_t cmd_pid, dn_req_pid;
   sbs_pkg::sbs_res_t res_code;
   sbs_pkg::sbs_hsk_t dn_done_result, dn_res;
   logic [`SBS_ADDR_W-1:0] cmd_addr, adr, dn_req_addr, paddr;
   logic [`SBS_EP_W-1:0] cmd_endp, dn_req_endp, pendp;
   logic [7:0] cmd_data, res_data, dn_req_data, dn_done_data, d1;
   logic [1:0] res_err_count;
   logic [0:0] dn_req_idx, dn_done_idx, pidx;
   int seed = 32'h3BDC, err_total = 0, total_checks = 0, dly = 0;
   int req_cnt [16];
   logic [7:0] req_dat [16];

   sbs_link_if lnk ();
   // short timeouts keep fault retries quick; host one must exceed the translator's 4
   sbs_tt_end #(.TO_CYC(4)) sbs_tt_end_i (.clock(clock), .rst(rst),
      .lnk(lnk), .dn_req_valid(dn_req_valid), .dn_req_idx(dn_req_idx),
      .dn_req_addr(dn_req_addr), .dn_req_endp(dn_req_endp),
      .dn_req_pid(dn_req_pid), .dn_req_data(dn_req_data),
      .dn_done(dn_done), .dn_done_idx(dn_done_idx),
      .dn_done_result(dn_done_result), .dn_done_data(dn_done_data));
   sbs_hc_end #(.TO_CYC(12)) sbs_hc_end_i (.clock(clock), .rst(rst),
      .lnk(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_complete(cmd_complete), .cmd_pid(cmd_pid), .cmd_ctrl(cmd_ctrl),
      .cmd_addr(cmd_addr), .cmd_endp(cmd_endp), .cmd_data(cmd_data),
      .cmd_bad_crc(cmd_bad_crc), .cmd_drop_token(cmd_drop_token),
      .res_valid(res_valid), .res_code(res_code), .res_data(res_data),
      .res_err_count(res_err_count));
   sbs_link_sva sbs_link_sva_i (.clock(clock), .rst(rst),
      .ss_valid(lnk.ss_valid), .cs_valid(lnk.cs_valid),
      .ss_ctrl(lnk.ss_ctrl), .tok_valid(lnk.tok_valid),
      .tok_pid(lnk.tok_pid), .data_valid(lnk.data_valid),
      .data_crc_ok(lnk.data_crc_ok), .hsk_valid(lnk.hsk_valid),
      .hsk_code(lnk.hsk_code));

   // in-data the downstream stand-in returns for an address and endpoint
   function automatic logic [7:0] exp_dat(input logic [6:0] a,
      input logic [3:0] e);
      return {a[3:0], e} ^ 8'hA5;
   endfunction : exp_dat

   task automatic complete_run;
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   task automatic chk(input logic ok);
      total_checks++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("[FAIL] %0t downstream request count or payload", $time);
      end
   endtask : chk

   // one host command; complete-splits are repeated while still pending
   task automatic xfer(input logic comp, input sbs_pkg::sbs_pid_t pid,
      input logic ctrl, input logic [3:0] ep, input logic [1:0] flt,
      input sbs_pkg::sbs_res_t exp);
      int n;
      int k;
      n = 0;
      do
      begin
         @(posedge clock);
         #1;
         cmd_valid = 1'b1;
         cmd_complete = comp;
         cmd_pid = pid;
         cmd_ctrl = ctrl;
         cmd_endp = ep;
         cmd_addr = adr;
         cmd_data = $random(seed);
         cmd_bad_crc = flt[0];
         cmd_drop_token = flt[1];
         @(negedge clock);
         for (k = 0; k < 50 && cmd_ready !== 1'b1; k++)
            @(negedge clock);
         @(posedge clock);
         #1 cmd_valid = 1'b0;
         for (k = 0; k < 300 && res_valid !== 1'b1; k++)
            @(negedge clock);
         n++;
      end
      while (comp && res_code === sbs_pkg::RES_NYET &&
         exp !== sbs_pkg::RES_NYET && n < 8);
      total_checks++;
      if (res_code !== exp || res_err_count !== {1'b0, flt != 2'b00} ||
         (exp === sbs_pkg::RES_DATA && res_data !== exp_dat(adr, ep)))
      begin
         err_total++;
         $display("[FAIL] %0t ep %0d got %0d want %0d", $time, ep,
            res_code, exp);
      end
   endtask : xfer

   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // downstream stand-in: one request at a time, random answer delay
   always @(posedge clock)
   begin
      #1;
      dn_done = 1'b0;
      if (dn_req_valid === 1'b1)
      begin
         pend = 1'b1;
         pidx = dn_req_idx;
         paddr = dn_req_addr;
         pendp = dn_req_endp;
         req_cnt[dn_req_endp]++;
         req_dat[dn_req_endp] = dn_req_data;
         dly = $unsigned($random(seed)) % 4;
      end
      else if (pend && !dn_hold)
      begin
         if (dly > 0)
            dly--;
         else
         begin
            dn_done = 1'b1;
            dn_done_idx = pidx;
            dn_done_result = dn_res;
            dn_done_data = exp_dat(paddr, pendp);
            pend = 1'b0;
         end
      end
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      err_total++;
      complete_run;
   end

   initial
   begin
      rst = 1'b1;
      {cmd_valid, cmd_complete, cmd_ctrl, cmd_bad_crc, cmd_drop_token} = '0;
      {dn_done, pend, dn_done_idx, dn_done_data} = '0;
      cmd_pid = sbs_pkg::PID_OUT;
      {cmd_addr, cmd_endp, cmd_data} = '0;
      dn_done_result = sbs_pkg::HSK_ACK;
      dn_res = sbs_pkg::HSK_ACK;
      dn_hold = 1'b1;
      foreach (req_cnt[i]) req_cnt[i] = 0;
      adr = $random(seed);
      repeat (3) @(posedge clock);
      #1 rst = 1'b0;
      // downstream stalled: fill both buffers, then probe matching
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h1, 0, sbs_pkg::RES_ACK);
      d1 = cmd_data;
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h1, 0, sbs_pkg::RES_NYET);
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h2, 0, sbs_pkg::RES_ACK);
      xfer(0, sbs_pkg::PID_IN, 0, 4'h1, 0, sbs_pkg::RES_NAK);
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h1, 0, sbs_pkg::RES_ACK);
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h3, 0, sbs_pkg::RES_NAK);
      @(posedge clock);
      #1 dn_hold = 1'b0;
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h1, 0, sbs_pkg::RES_ACK);
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h1, 0, sbs_pkg::RES_STALL);
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h2, 0, sbs_pkg::RES_ACK);
      chk(req_cnt[1] == 1 && req_dat[1] === d1);
      // control endpoints match regardless of direction
      @(posedge clock);
      #1 dn_hold = 1'b1;
      xfer(0, sbs_pkg::PID_SETUP, 1, 4'h5, 0, sbs_pkg::RES_ACK);
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h7, 0, sbs_pkg::RES_ACK);
      xfer(0, sbs_pkg::PID_IN, 1, 4'h5, 0, sbs_pkg::RES_ACK);
      @(posedge clock);
      #1 dn_hold = 1'b0;
      xfer(1, sbs_pkg::PID_SETUP, 1, 4'h5, 0, sbs_pkg::RES_ACK);
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h7, 0, sbs_pkg::RES_ACK);
      chk(req_cnt[5] == 1);
      dn_res = sbs_pkg::HSK_DATA;
      xfer(0, sbs_pkg::PID_IN, 0, 4'h8, 0, sbs_pkg::RES_ACK);
      xfer(1, sbs_pkg::PID_IN, 0, 4'h8, 0, sbs_pkg::RES_DATA);
      dn_res = sbs_pkg::HSK_ACK;
      // first attempt broken on purpose: one error, then accepted
      xfer(0, sbs_pkg::PID_OUT, 0, 4'h9, 2'b01, sbs_pkg::RES_ACK);
      xfer(1, sbs_pkg::PID_OUT, 0, 4'h9, 0, sbs_pkg::RES_ACK);
      xfer(0, sbs_pkg::PID_IN, 0, 4'hA, 2'b10, sbs_pkg::RES_ACK);
      complete_run;
   end
endmodule : testbench
